// *** logic/sp0_pkg.sv ***
package sp0_pkg;

   // register addresses on the special-function port
   localparam logic [7:0] ADDR_POWER_CTRL = 8'h87;
   localparam logic [7:0] ADDR_SERIAL_CTRL = 8'h98;
   localparam logic [7:0] ADDR_DATA_BUF = 8'h99;
   localparam logic [7:0] ADDR_IRQ_ENABLE_BITS = 8'ha8;
   localparam logic [7:0] ADDR_SLAVE_MATCH = 8'ha9;
   localparam logic [7:0] ADDR_ADDRESS_MASK = 8'hb9;
   localparam logic [7:0] ADDR_EVENT_STATUS = 8'hda;
   localparam logic [7:0] ADDR_EVENT_ENABLE = 8'hdb;
   localparam logic [7:0] ADDR_EVENT_CLEAR = 8'hdc;
   localparam logic [7:0] ADDR_BAUD_DIV = 8'hdd;

   // serial control fields
   localparam int CTRL_MODE0_FE = 7;
   localparam int CTRL_MODE_HIGH = 6;
   localparam int CTRL_MPROC = 5;
   localparam int CTRL_RX_EN = 4;
   localparam int CTRL_TX_NINTH = 3;
   localparam int CTRL_RX_NINTH = 2;
   localparam int CTRL_TX_DONE = 1;
   localparam int CTRL_RX_DONE = 0;

   // power control fields
   localparam int POWER_CONTROL_REG_BAUD_DOUBLER = 7;
   localparam int POWER_CONTROL_REG_FRAME_CHECK = 6;

   // interrupt enable fields
   localparam int IEN_GLOBAL = 7;
   localparam int IEN_SERIAL0 = 4;

   // event status bits
   localparam int EV_TX_DONE = 0;
   localparam int EV_RX_DONE = 1;
   localparam int EV_FRAME_ERR = 2;

   // reset values
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] RESET_BAUD_DIV = 8'h00;

   // mode 0 shift clock: 12 or 4 oscillator clocks per bit
   localparam int M0_SLOW_CLKS = 12;
   localparam int M0_FAST_CLKS = 4;
   localparam logic [3:0] M0_SLOW_LAST = 4'(M0_SLOW_CLKS - 1);
   localparam logic [3:0] M0_FAST_LAST = 4'(M0_FAST_CLKS - 1);

   // async bit split into 16 ticks; mode 2 bit is 64 or 32 clocks
   localparam int OVERSAMPLE = 16;
   localparam int M2_BIT_CLKS = 64;
   localparam logic [8:0] M2_TICK_LAST_SLOW = 9'(M2_BIT_CLKS / OVERSAMPLE - 1);
   localparam logic [8:0] M2_TICK_LAST_FAST = 9'(M2_BIT_CLKS / OVERSAMPLE / 2 - 1);
   localparam logic [3:0] TICK_MID = 4'h7;
   localparam logic [3:0] TICK_LAST = 4'hf;
   localparam logic [2:0] LAST_DATA_BIT = 3'h7;

   typedef enum logic [2:0] {
      TX_IDLE = 3'b000,
      TX_WAIT = 3'b001,
      TX_START = 3'b010,
      TX_DATA = 3'b011,
      TX_NINTH = 3'b100,
      TX_STOP = 3'b101
   } sp0_tx_state_t;

   typedef enum logic [2:0] {
      RX_IDLE = 3'b000,
      RX_START = 3'b001,
      RX_DATA = 3'b010,
      RX_NINTH = 3'b011,
      RX_STOP = 3'b100
   } sp0_rx_state_t;

endpackage : sp0_pkg

// *** logic/sp0_uart.sv ***
module sp0_uart
   import sp0_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register port
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   // serial pins
   output logic txd,
   input wire logic rxd_in,
   output logic rxd_out,
   output logic rxd_oe_n,
   // interrupts
   output logic irq,
   output logic serial0_irq
);

   // masked compare of a received address byte
   function automatic logic sp0_addr_match(input logic [7:0] data, input logic [7:0] match,
                                           input logic [7:0] mask);
      sp0_addr_match = ((data ^ match) & mask) == 8'h00;
   endfunction : sp0_addr_match

   // register state
   logic mode_bit0_or_frame_error;
   logic frame_error;
   logic mode_select_high;
   logic multiproc_filter;
   logic receive_enable;
   logic ninth_bit_to_send;
   logic ninth_bit_received;
   logic tx_done_flag;
   logic rx_done_flag;
   logic [7:0] rx_buf;
   logic [7:0] interrupt_enable_bits;
   logic [7:0] slave_match_address;
   logic [7:0] address_mask;
   logic [7:0] power_control_reg;
   logic [7:0] baud_div;
   logic [2:0] event_status;
   logic [2:0] event_enable;

   // datapath state
   sp0_tx_state_t tx_state;
   sp0_rx_state_t rx_state;
   logic [3:0] tx_sub;
   logic [3:0] rx_sub;
   logic [2:0] tx_cnt;
   logic [2:0] rx_cnt;
   logic [7:0] tx_shift;
   logic [7:0] rx_shift;
   logic rx_ninth;
   logic rxd_prev;
   logic [8:0] bcnt;
   logic [3:0] m0cnt;

   // address decode
   wire wr_ctrl = wr && (addr == ADDR_SERIAL_CTRL);
   wire wr_data = wr && (addr == ADDR_DATA_BUF);
   wire wr_ien = wr && (addr == ADDR_IRQ_ENABLE_BITS);
   wire wr_match = wr && (addr == ADDR_SLAVE_MATCH);
   wire wr_mask = wr && (addr == ADDR_ADDRESS_MASK);
   wire wr_power_control_reg = wr && (addr == ADDR_POWER_CTRL);
   wire wr_ev_en = wr && (addr == ADDR_EVENT_ENABLE);
   wire wr_ev_clr = wr && (addr == ADDR_EVENT_CLEAR);
   wire wr_baud = wr && (addr == ADDR_BAUD_DIV);

   // mode decode
   wire baud_doubler = power_control_reg[POWER_CONTROL_REG_BAUD_DOUBLER];
   wire frame_check_select = power_control_reg[POWER_CONTROL_REG_FRAME_CHECK];
   wire [1:0] mode = {mode_bit0_or_frame_error, mode_select_high};
   wire mode0 = (mode == 2'b00);
   wire mode1 = (mode == 2'b01);
   wire mode2 = (mode == 2'b10);
   wire nine_bit = mode_bit0_or_frame_error; // modes 2 and 3 carry a ninth bit
   wire ctrl_bit7 = frame_check_select ? frame_error : mode_bit0_or_frame_error;

   // 16x tick: mode 2 fixed, modes 1 and 3 from the divider, halved by doubler
   wire [8:0] m2_last = baud_doubler ? M2_TICK_LAST_FAST : M2_TICK_LAST_SLOW;
   wire [8:0] var_last = baud_doubler ? {1'b0, baud_div} : {baud_div, 1'b1};
   wire [8:0] tick_last = mode2 ? m2_last : var_last;
   wire btick = (bcnt >= tick_last);

   // mode 0 bit timing; the shift clock is low in the first half of a bit
   wire [3:0] m0_last = multiproc_filter ? M0_FAST_LAST : M0_SLOW_LAST;
   wire [3:0] m0_half = m0_last >> 1;
   wire m0_end = (m0cnt == m0_last);
   wire [3:0] m0_next = m0_end ? 4'h0 : m0cnt + 4'h1;
   wire sclk_next = (m0_next > m0_half);
   wire m0_sample = (m0cnt == m0_half);

   // transmit bit steps and done event
   wire tx_step = mode0 ? m0_end : (btick && tx_sub == TICK_LAST);
   wire tx_busy = (tx_state != TX_IDLE);
   wire ti_set = tx_step && ((tx_state == TX_DATA && tx_cnt == LAST_DATA_BIT && (mode0 || !nine_bit))
                             || tx_state == TX_NINTH);

   // receive sample points and frame completion
   wire rx_mid = btick && (rx_sub == TICK_MID);
   wire rx_end = btick && (rx_sub == TICK_LAST);
   wire rx_m0_active = mode0 && (rx_state == RX_DATA);
   wire rx_finish = mode0 ? (rx_state == RX_DATA && m0_end && rx_cnt == LAST_DATA_BIT)
                          : (rx_state == RX_STOP && rx_mid);
   // mode 0 receive clock: low from the start boundary like transmit, held high after the last bit
   wire rx_m0_go = mode0 && receive_enable && (rx_state == RX_IDLE) && m0_end && !rx_done_flag && !tx_busy;
   wire rx_m0_clk = rx_m0_go ? 1'b0 : ((rx_m0_active && !rx_finish) ? sclk_next : 1'b1);
   wire addr_ok = sp0_addr_match(rx_shift, slave_match_address, address_mask);
   wire accept_m1 = !multiproc_filter || rxd_in;
   wire accept_m23 = !multiproc_filter || (rx_ninth && addr_ok);
   wire accept = mode0 ? 1'b1 : (mode1 ? accept_m1 : accept_m23);
   wire rx_load = rx_finish && !rx_done_flag && accept;
   wire fe_set = rx_finish && !mode0 && !rxd_in;
   wire load_rb8 = rx_load && !mode0 && (nine_bit || !multiproc_filter);
   wire rb8_value = nine_bit ? rx_ninth : rxd_in;
   wire [2:0] events = {fe_set, rx_load, ti_set};

   // read mux
   wire [7:0] ctrl_read = {ctrl_bit7, mode_select_high, multiproc_filter, receive_enable,
                           ninth_bit_to_send, ninth_bit_received, tx_done_flag, rx_done_flag};
   wire [7:0] read_mux = (addr == ADDR_SERIAL_CTRL) ? ctrl_read :
                         (addr == ADDR_DATA_BUF) ? rx_buf :
                         (addr == ADDR_IRQ_ENABLE_BITS) ? interrupt_enable_bits :
                         (addr == ADDR_SLAVE_MATCH) ? slave_match_address :
                         (addr == ADDR_ADDRESS_MASK) ? address_mask :
                         (addr == ADDR_POWER_CTRL) ? power_control_reg :
                         (addr == ADDR_EVENT_STATUS) ? {5'h00, event_status} :
                         (addr == ADDR_EVENT_ENABLE) ? {5'h00, event_enable} :
                         (addr == ADDR_BAUD_DIV) ? baud_div : 8'h00;
   wire serial_req = tx_done_flag || rx_done_flag;

   // read data, valid only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata <= RESET_BYTE;
      end else begin
         rdata <= rd ? read_mux : RESET_BYTE;
      end
   end

   // plain software registers
   always_ff @(posedge clk) begin
      if (rst) begin
         interrupt_enable_bits <= RESET_BYTE;
         slave_match_address <= RESET_BYTE;
         address_mask <= RESET_BYTE;
         power_control_reg <= RESET_BYTE;
         baud_div <= RESET_BAUD_DIV;
         event_enable <= 3'h0;
      end else begin
         if (wr_ien) interrupt_enable_bits <= wdata;
         if (wr_match) slave_match_address <= wdata;
         if (wr_mask) address_mask <= wdata;
         if (wr_power_control_reg) power_control_reg <= wdata;
         if (wr_baud) baud_div <= wdata;
         if (wr_ev_en) event_enable <= wdata[2:0];
      end
   end

   // serial control: hardware set wins over a software write in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         mode_bit0_or_frame_error <= 1'b0;
         frame_error <= 1'b0;
         mode_select_high <= 1'b0;
         multiproc_filter <= 1'b0;
         receive_enable <= 1'b0;
         ninth_bit_to_send <= 1'b0;
         ninth_bit_received <= 1'b0;
         tx_done_flag <= 1'b0;
         rx_done_flag <= 1'b0;
      end else begin
         if (wr_ctrl && !frame_check_select) mode_bit0_or_frame_error <= wdata[CTRL_MODE0_FE];
         frame_error <= fe_set || ((wr_ctrl && frame_check_select) ? wdata[CTRL_MODE0_FE] : frame_error);
         if (wr_ctrl) begin
            mode_select_high <= wdata[CTRL_MODE_HIGH];
            multiproc_filter <= wdata[CTRL_MPROC];
            receive_enable <= wdata[CTRL_RX_EN];
            ninth_bit_to_send <= wdata[CTRL_TX_NINTH];
         end
         ninth_bit_received <= load_rb8 ? rb8_value : (wr_ctrl ? wdata[CTRL_RX_NINTH] : ninth_bit_received);
         tx_done_flag <= ti_set || (wr_ctrl ? wdata[CTRL_TX_DONE] : tx_done_flag);
         rx_done_flag <= rx_load || (wr_ctrl ? wdata[CTRL_RX_DONE] : rx_done_flag);
      end
   end

   // receive buffer is a separate register from the transmit shifter
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_buf <= RESET_BYTE;
      end else if (rx_load) begin
         rx_buf <= rx_shift;
      end
   end

   // event status, enable and interrupt outputs
   always_ff @(posedge clk) begin
      if (rst) begin
         event_status <= 3'h0;
         irq <= 1'b0;
         serial0_irq <= 1'b0;
      end else begin
         event_status <= (event_status & ~(wr_ev_clr ? wdata[2:0] : 3'h0)) | events;
         irq <= |(event_status & event_enable);
         serial0_irq <= interrupt_enable_bits[IEN_GLOBAL] && interrupt_enable_bits[IEN_SERIAL0]
                        && serial_req;
      end
   end

   // bit timing counters run freely
   always_ff @(posedge clk) begin
      if (rst) begin
         bcnt <= 9'h000;
         m0cnt <= 4'h0;
      end else begin
         bcnt <= btick ? 9'h000 : bcnt + 9'h001;
         m0cnt <= m0_next;
      end
   end

   // transmitter; in mode 0 the transmit pin carries the shift clock
   always_ff @(posedge clk) begin
      if (rst) begin
         tx_state <= TX_IDLE;
         tx_sub <= 4'h0;
         tx_cnt <= 3'h0;
         tx_shift <= RESET_BYTE;
         txd <= 1'b1;
         rxd_out <= 1'b1;
         rxd_oe_n <= 1'b1;
      end else begin
         if (btick) tx_sub <= tx_sub + 4'h1;
         case (tx_state)
            TX_IDLE: begin
               rxd_oe_n <= 1'b1;
               txd <= rx_m0_clk;
               if (wr_data) begin
                  tx_shift <= wdata;
                  tx_cnt <= 3'h0;
                  tx_sub <= 4'h0;
                  tx_state <= mode0 ? TX_WAIT : TX_START;
                  if (!mode0) txd <= 1'b0;
               end
            end
            TX_WAIT: begin
               if (m0_end) begin
                  tx_state <= TX_DATA;
                  rxd_oe_n <= 1'b0;
                  rxd_out <= tx_shift[0];
                  txd <= 1'b0;
               end
            end
            TX_START: begin
               if (tx_step) begin
                  tx_state <= TX_DATA;
                  txd <= tx_shift[0];
               end
            end
            TX_DATA: begin
               if (mode0) txd <= sclk_next;
               if (tx_step) begin
                  tx_shift <= tx_shift >> 1;
                  tx_cnt <= tx_cnt + 3'h1;
                  if (tx_cnt != LAST_DATA_BIT) begin
                     if (mode0) rxd_out <= tx_shift[1];
                     else txd <= tx_shift[1];
                  end else if (mode0) begin
                     tx_state <= TX_IDLE;
                     rxd_oe_n <= 1'b1;
                     txd <= 1'b1;
                  end else if (nine_bit) begin
                     tx_state <= TX_NINTH;
                     txd <= ninth_bit_to_send;
                  end else begin
                     tx_state <= TX_STOP;
                     txd <= 1'b1;
                  end
               end
            end
            TX_NINTH: begin
               if (tx_step) begin
                  tx_state <= TX_STOP;
                  txd <= 1'b1;
               end
            end
            TX_STOP: begin
               if (tx_step) tx_state <= TX_IDLE;
            end
            default: begin
               tx_state <= TX_IDLE;
               txd <= 1'b1;
            end
         endcase
      end
   end

   // receiver
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_state <= RX_IDLE;
         rx_sub <= 4'h0;
         rx_cnt <= 3'h0;
         rx_shift <= RESET_BYTE;
         rx_ninth <= 1'b0;
         rxd_prev <= 1'b1;
      end else begin
         rxd_prev <= rxd_in;
         if (btick) rx_sub <= rx_sub + 4'h1;
         if (!receive_enable) begin
            rx_state <= RX_IDLE;
         end else begin
            case (rx_state)
               RX_IDLE: begin
                  rx_cnt <= 3'h0;
                  rx_sub <= 4'h0;
                  if (mode0) begin
                     if (rx_m0_go) rx_state <= RX_DATA;
                  end else if (rxd_prev && !rxd_in) begin
                     rx_state <= RX_START;
                  end
               end
               RX_START: begin
                  if (rx_mid && rxd_in) rx_state <= RX_IDLE;
                  else if (rx_end) rx_state <= RX_DATA;
               end
               RX_DATA: begin
                  if (mode0 ? m0_sample : rx_mid) rx_shift <= {rxd_in, rx_shift[7:1]};
                  if (mode0 ? m0_end : rx_end) begin
                     rx_cnt <= rx_cnt + 3'h1;
                     if (rx_cnt == LAST_DATA_BIT) begin
                        rx_state <= mode0 ? RX_IDLE : (nine_bit ? RX_NINTH : RX_STOP);
                     end
                  end
               end
               RX_NINTH: begin
                  if (rx_mid) rx_ninth <= rxd_in;
                  if (rx_end) rx_state <= RX_STOP;
               end
               RX_STOP: begin
                  if (rx_mid) rx_state <= RX_IDLE;
               end
               default: begin
                  rx_state <= RX_IDLE;
               end
            endcase
         end
      end
   end

endmodule : sp0_uart

// *** sim/sp0_uart_chk.sv ***
module sp0_uart_chk
   import sp0_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register port
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   // serial pins
   input wire logic txd,
   input wire logic rxd_in,
   input wire logic rxd_out,
   input wire logic rxd_oe_n,
   // interrupts
   input wire logic irq,
   input wire logic serial0_irq
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   logic fcs_sh, filt_sh, en_sh;
   logic [1:0] mode_sh;
   logic [7:0] hi_cnt;
   wire logic m0 = (mode_sh == 2'b00);
   // shadow copies of mode, filter, frame check select and serial irq enables
   always_ff @(posedge clk) begin
      if (rst) begin
         fcs_sh <= 1'b0;
         filt_sh <= 1'b0;
         en_sh <= 1'b0;
         mode_sh <= 2'b00;
      end else begin
         if (wr && addr == ADDR_SERIAL_CTRL) begin
            mode_sh[0] <= wdata[CTRL_MODE_HIGH];
            filt_sh <= wdata[CTRL_MPROC];
            if (!fcs_sh) begin
               mode_sh[1] <= wdata[CTRL_MODE0_FE];
            end
         end
         if (wr && addr == ADDR_POWER_CTRL) begin
            fcs_sh <= wdata[POWER_CONTROL_REG_FRAME_CHECK];
         end
         if (wr && addr == ADDR_IRQ_ENABLE_BITS) begin
            en_sh <= wdata[IEN_GLOBAL] & wdata[IEN_SERIAL0];
         end
      end
   end
   // run length of txd high, saturating, marks a surely idle transmitter
   always_ff @(posedge clk) begin
      if (rst || !txd) begin
         hi_cnt <= 8'h00;
      end else begin
         hi_cnt <= hi_cnt + {7'h00, hi_cnt != 8'hff};
      end
   end
   AST_RDATA_REST: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data not zero outside the answer cycle");
   AST_UNMAPPED: assert property (rd && addr == 8'h00 |=> rdata == 8'h00)
      else $error("unmapped read returned data");
   AST_RESET_IDLE: assert property ($past(rst) |-> txd && rxd_oe_n && !irq && !serial0_irq)
      else $error("pins or interrupts not idle after reset");
   AST_SER_GATE: assert property (serial0_irq |-> $past(en_sh))
      else $error("serial interrupt without both enables");
   AST_SER_DROP: assert property (wr && addr == ADDR_IRQ_ENABLE_BITS && !wdata[IEN_GLOBAL] |-> ##[1:2] !serial0_irq)
      else $error("serial interrupt stays after global disable");
   AST_TX_START: assert property (wr && addr == ADDR_DATA_BUF && !m0 && hi_cnt == 8'hff |=> !txd)
      else $error("buffer write on idle transmitter gave no start bit");
   AST_M0_SLOW: assert property ($fell(txd) && m0 && !filt_sh |=> !txd [*5] ##1 txd)
      else $error("slow shift clock low phase not six cycles");
   AST_M0_FAST: assert property ($fell(txd) && m0 && filt_sh |=> !txd ##1 txd)
      else $error("fast shift clock low phase not two cycles");
   AST_OE_M0: assert property (!rxd_oe_n |-> m0)
      else $error("receive pin driven outside shift mode");
endmodule : sp0_uart_chk

bind sp0_uart sp0_uart_chk i_sp0_uart_chk (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .txd(txd), .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n), .irq(irq),
   .serial0_irq(serial0_irq));

// *** sim/sp0_peer.sv ***
module sp0_peer (
   // clock
   input wire logic clk,
   // serial lines from the port
   input wire logic txd,
   input wire logic rxd_out,
   // serial line into the port
   output logic rxd_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // line idles high
   initial rxd_in = 1'b1;
   // async frame: start 0, data lsb first, optional ninth bit, stop
   task automatic send(input logic [8:0] d, input int n, input logic stp, input int bc);
      for (int i = 0; i < n + 2; i++) begin
         rxd_in <= (i == 0) ? 1'b0 : ((i > n) ? stp : d[i - 1]);
         repeat (bc) @(posedge clk);
      end
      rxd_in <= 1'b1;
   endtask : send
   // sample each bit centre after the falling start edge, stop bit last
   task automatic recv(input int n, input int bc, output logic [9:0] d);
      d = 10'h000;
      @(negedge txd);
      repeat (bc / 2) @(posedge clk);
      for (int i = 0; i <= n; i++) begin
         repeat (bc) @(posedge clk);
         d[i] = txd;
      end
   endtask : recv
   // shift mode: data taken on each rising shift clock
   task automatic m0_recv(output logic [7:0] d);
      for (int i = 0; i < 8; i++) begin
         @(posedge txd);
         d[i] = rxd_out;
      end
   endtask : m0_recv
   // shift mode: next bit placed after each rising shift clock
   task automatic m0_send(input logic [7:0] d);
      rxd_in <= d[0];
      for (int i = 1; i < 9; i++) begin
         @(posedge txd);
         @(posedge clk);
         rxd_in <= (i < 8) ? d[i] : 1'b1;
      end
   endtask : m0_send
endmodule : sp0_peer

// *** sim/sp0_uart_bench.sv ***
module sp0_uart_bench import sp0_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} sp0_row_t;
   typedef struct {logic [7:0] c; logic [7:0] k; logic [8:0] d; int n; int bc; logic [7:0] ec; logic [7:0] ed;} sp0_rx_t;
   localparam int LIMIT = 40000;
   logic clk, rst, wr, rd, txd, rxd_in, rxd_out, rxd_oe_n, irq, serial0_irq;
   logic [7:0] addr, wdata, rdata, b;
   logic [9:0] got;
   int errors = 0;
   int check_count = 0;
   int cyc = 0;
   sp0_row_t rows[9] = '{'{ADDR_IRQ_ENABLE_BITS, 8'h90, 8'h90}, '{ADDR_SLAVE_MATCH, 8'h5a, 8'h5a},
      '{ADDR_ADDRESS_MASK, 8'hff, 8'hff}, '{ADDR_BAUD_DIV, 8'h02, 8'h02}, '{ADDR_EVENT_ENABLE, 8'h03, 8'h03},
      '{ADDR_POWER_CTRL, 8'h0c, 8'h0c}, '{ADDR_EVENT_CLEAR, 8'h07, 8'h00}, '{ADDR_EVENT_STATUS, 8'h07, 8'h00},
      '{8'h00, 8'h5a, 8'h00}};
   logic [7:0] tx_c[4] = '{8'h48, 8'h88, 8'hc8, 8'h80};
   int tx_bc[4] = '{96, 64, 48, 32};
   logic [9:0] tx_e[4] = '{10'h16a, 10'h36b, 10'h36c, 10'h26d};
   sp0_rx_t rx_rows[7] = '{'{8'h50, 8'h00, 9'h03c, 8, 96, 8'h55, 8'h3c}, '{8'h40, 8'h00, 9'h0c3, 8, 96, 8'h40, 8'h3c},
      '{8'hb0, 8'h00, 9'h011, 9, 64, 8'hb0, 8'h3c}, '{8'hb0, 8'h00, 9'h122, 9, 64, 8'hb5, 8'h22},
      '{8'hb0, 8'hff, 9'h133, 9, 64, 8'hb0, 8'h22}, '{8'hb0, 8'hff, 9'h15a, 9, 64, 8'hb5, 8'h5a},
      '{8'hf0, 8'h0f, 9'h13a, 9, 96, 8'hf5, 8'h3a}};
   sp0_uart i_sp0_uart (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .txd(txd), .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n), .irq(irq), .serial0_irq(serial0_irq));
   sp0_peer i_sp0_peer (.clk(clk), .txd(txd), .rxd_out(rxd_out), .rxd_in(rxd_in));
   // 100 MHz clock
   always #5 clk = ~clk;
   // hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         errors++;
         close_out();
      end
   end
   // compare and count
   task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // one-cycle register write
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg
   // one-cycle read, data taken in the following cycle
   task automatic chk_reg(input string what, input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check(what, {2'b00, rdata}, {2'b00, e});
   endtask : chk_reg
   // counts and verdict
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : close_out
   // main sequence
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      foreach (rows[i]) begin
         chk_reg("reset value", rows[i].a, RESET_BYTE);
         wreg(rows[i].a, rows[i].d);
         chk_reg("read back", rows[i].a, rows[i].e);
      end
      $display("register table done");
      for (int m = 0; m < 4; m++) begin
         wreg(ADDR_POWER_CTRL, (m >= 2) ? 8'h80 : 8'h00);
         wreg(ADDR_SERIAL_CTRL, tx_c[m]);
         fork
            i_sp0_peer.recv((m == 0) ? 8 : 9, tx_bc[m], got);
            wreg(ADDR_DATA_BUF, 8'(8'h6a + m));
         join
         check("tx frame", got, tx_e[m]);
         check("tx irq", {9'h000, serial0_irq}, 10'h001);
         repeat (300) @(posedge clk);
         chk_reg("tx done", ADDR_SERIAL_CTRL, tx_c[m] | 8'h02);
      end
      for (int f = 0; f < 2; f++) begin
         wreg(ADDR_SERIAL_CTRL, (f == 1) ? 8'h20 : 8'h00);
         fork
            i_sp0_peer.m0_recv(b);
            wreg(ADDR_DATA_BUF, 8'(8'h96 - f));
         join
         check("shift out", {2'b00, b}, {2'b00, 8'(8'h96 - f)});
         repeat (20) @(posedge clk);
      end
      fork
         i_sp0_peer.m0_send(8'h5c);
         wreg(ADDR_SERIAL_CTRL, 8'h30);
      join
      repeat (8) @(posedge clk);
      chk_reg("shift in", ADDR_DATA_BUF, 8'h5c);
      chk_reg("shift done", ADDR_SERIAL_CTRL, 8'h31);
      wreg(ADDR_SERIAL_CTRL, 8'h00);
      $display("transmit and shift tests done");
      wreg(ADDR_POWER_CTRL, 8'h00);
      wreg(ADDR_EVENT_CLEAR, 8'h07);
      wreg(ADDR_SERIAL_CTRL, 8'h70);
      i_sp0_peer.send(9'h0a5, 8, 1'b0, 96);
      chk_reg("bad stop flags", ADDR_SERIAL_CTRL, 8'h70);
      chk_reg("bad stop status", ADDR_EVENT_STATUS, 8'h04);
      check("irq masked", {9'h000, irq}, 10'h000);
      wreg(ADDR_EVENT_ENABLE, 8'h07);
      @(posedge clk);
      #1;
      check("irq raised", {9'h000, irq}, 10'h001);
      wreg(ADDR_EVENT_CLEAR, 8'h04);
      @(posedge clk);
      #1;
      check("irq cleared", {9'h000, irq}, 10'h000);
      chk_reg("status cleared", ADDR_EVENT_STATUS, 8'h00);
      wreg(ADDR_POWER_CTRL, 8'h40);
      chk_reg("error flag view", ADDR_SERIAL_CTRL, 8'hf0);
      wreg(ADDR_SERIAL_CTRL, 8'h40);
      chk_reg("error flag clear", ADDR_SERIAL_CTRL, 8'h40);
      wreg(ADDR_POWER_CTRL, 8'h00);
      $display("framing error and interrupt tests done");
      foreach (rx_rows[i]) begin
         wreg(ADDR_ADDRESS_MASK, rx_rows[i].k);
         wreg(ADDR_SERIAL_CTRL, rx_rows[i].c);
         i_sp0_peer.send(rx_rows[i].d, rx_rows[i].n, 1'b1, rx_rows[i].bc);
         chk_reg("rx flags", ADDR_SERIAL_CTRL, rx_rows[i].ec);
         chk_reg("rx data", ADDR_DATA_BUF, rx_rows[i].ed);
      end
      $display("receive tests done");
      check("rx irq", {9'h000, serial0_irq}, 10'h001);
      wreg(ADDR_IRQ_ENABLE_BITS, 8'h10);
      @(posedge clk);
      #1;
      check("global gate", {9'h000, serial0_irq}, 10'h000);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      chk_reg("reset ctrl", ADDR_SERIAL_CTRL, RESET_BYTE);
      chk_reg("reset buffer", ADDR_DATA_BUF, RESET_BYTE);
      check("reset pins", {7'h00, txd, rxd_oe_n, serial0_irq}, 10'h006);
      $display("mid-run reset tests done");
      close_out();
   end
endmodule : sp0_uart_bench
